// ===== line_loss_pkg.sv
// package: register map, field layout, timing counts and carriers for the loss monitor
package line_loss_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] LINE_LOSS_STATUS_ADDR = 8'h00;
  localparam logic [7:0] RECEIVE_PATH_CONFIG_ADDR = 8'h02;
  localparam int REG_WIDTH = 5;

  // status field positions
  localparam int ST_LOCK_LOSS_BIT = 4;
  localparam int ST_SIGNAL_LOSS_BIT = 3;
  localparam int ST_AMPLITUDE_LOSS_BIT = 2;
  localparam int ST_DENSITY_LOSS_BIT = 1;
  localparam int ST_DRIVE_MONITOR_BIT = 0;

  // configuration field positions
  localparam int CFG_CODEC_BYPASS_BIT = 3;
  localparam int CFG_AMP_DISABLE_BIT = 2;
  localparam int CFG_DENSITY_DISABLE_BIT = 1;
  localparam int CFG_EQ_BYPASS_BIT = 0;

  // reset value of the configuration register
  localparam logic [3:0] CFG_RESET = 4'h0;

  // ****************************************************************
  // timing counts, in unit intervals (recovered bit periods) except WINDOW_MIN_ONES (ones) and GOOD_WINDOWS (windows)
  // ****************************************************************
  localparam int ZERO_RUN_UI = 160;
  localparam int WINDOW_UI = 32;
  localparam int WINDOW_MIN_ONES = 10;
  localparam int GOOD_WINDOWS = 4;
  localparam int E3_MIN_UI = 10;
  localparam int E3_MAX_UI = 255;
  localparam int E3_FILTER_UI = 32;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic codec_bypass;
    logic amplitude_loss_disable;
    logic pulse_density_loss_disable;
    logic equalizer_bypass;
  } path_cfg_t;

  typedef struct packed {
    logic lock_loss_flag;
    logic signal_loss;
    logic amplitude_loss;
    logic pulse_density_loss;
    logic drive_monitor_flag;
  } loss_status_t;

endpackage

// ===== pulse_density_detector.sv
// module: zero-run declare and windowed ones-density clear detector
`timescale 1ns/10ps
module pulse_density_detector #(
  parameter int ZERO_RUN = line_loss_pkg::ZERO_RUN_UI,
  parameter int WINDOW = line_loss_pkg::WINDOW_UI,
  parameter int MIN_ONES = line_loss_pkg::WINDOW_MIN_ONES,
  parameter int GOOD_WIN = line_loss_pkg::GOOD_WINDOWS
) (
  input wire logic clk_i,      // system clock
  input wire logic rst_b_i,    // sync reset, active low
  input wire logic bit_en_i,   // one pulse per recovered bit
  input wire logic rx_bit_i,   // received bit, 1 = pulse
  input wire logic disable_i,  // detector disable
  output logic loss_o          // pulse-density loss state
);

  localparam int ZW = $clog2(ZERO_RUN + 1);
  localparam int IW = $clog2(WINDOW);
  localparam int OW = $clog2(WINDOW + 1);
  localparam int GW = $clog2(GOOD_WIN + 1);

  logic [ZW-1:0] zero_run_r;
  logic [IW-1:0] bit_idx_r;
  logic [OW-1:0] ones_r;
  logic [GW-1:0] good_r;
  logic [OW-1:0] ones_nxt;
  logic window_good;

  // ones in the window including the bit arriving now
  assign ones_nxt = ones_r + OW'(rx_bit_i);
  assign window_good = (ones_nxt >= OW'(MIN_ONES));

  // ****************************************************************
  // declare on zero run, clear on good windows
  // ****************************************************************
  // disable holds everything cleared so a re-enable starts fresh
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || disable_i) begin
      loss_o <= 1'b0;
      zero_run_r <= '0;
      bit_idx_r <= '0;
      ones_r <= '0;
      good_r <= '0;
    end else if (bit_en_i) begin
      if (!loss_o) begin
        // a one breaks the run; count clears to zero when the threshold declares loss
        if (rx_bit_i) begin
          zero_run_r <= '0;
        end else if (zero_run_r == ZW'(ZERO_RUN - 1)) begin
          loss_o <= 1'b1;
          zero_run_r <= '0;
        end else begin
          zero_run_r <= zero_run_r + ZW'(1);
        end
        bit_idx_r <= '0;
        ones_r <= '0;
        good_r <= '0;
      end else if (bit_idx_r == IW'(WINDOW - 1)) begin
        // window closes: one bad window restarts the good-window count
        bit_idx_r <= '0;
        ones_r <= '0;
        if (!window_good) begin
          good_r <= '0;
        end else if (good_r == GW'(GOOD_WIN - 1)) begin
          loss_o <= 1'b0;
          good_r <= '0;
        end else begin
          good_r <= good_r + GW'(1);
        end
      end else begin
        bit_idx_r <= bit_idx_r + IW'(1);
        ones_r <= ones_nxt;
      end
    end
  end

endmodule // pulse_density_detector

// ===== line_loss_monitor.sv
// module: loss-of-signal monitor top with register port and mode controls
`timescale 1ns/10ps

// Summary of operation
// - hardware mode: bypass pin selects codec enable
// - host mode: config bit D3 bypasses codec
// - missing signal drives loss pin and bit high
// - restored signal drives loss pin, bit low
// - E3 declare between 10 and 255 UI
// - E3 clear between 10 and 255 UI
// - DS3/STS-1 loss is amplitude OR density
// - status word: lock, signal, amplitude, density, monitor
// - amplitude bit shows current amplitude loss
// - config D2 disables amplitude detector
// - config D1 disables density detector
// - both disabled means loss never declared
// - declare density loss after 160 zeros
// - clear after four 32-bit windows, 10 ones
// - density bit shows current density loss
module line_loss_monitor #(
  parameter int E3_FILTER = line_loss_pkg::E3_FILTER_UI
) (
  input wire logic clk_i,                 // 10 MHz system clock
  input wire logic rst_b_i,               // sync reset, active low
  input wire logic host_mode_i,           // 1 = host mode, 0 = hardware mode
  input wire logic mode_e3_i,             // 1 = E3 rate, 0 = DS3/STS-1
  input wire logic bit_en_i,              // one pulse per recovered bit
  input wire logic rx_bit_i,              // received bit, 1 = pulse
  input wire logic amp_below_i,           // amplitude comparator, async
  input wire logic lock_loss_i,           // clock recovery lock loss, async
  input wire logic drive_monitor_i,       // transmit drive monitor, async
  input wire logic codec_bypass_pin_i,    // hardware-mode codec bypass pin
  input wire logic amp_disable_pin_i,     // hardware-mode amplitude disable pin
  input wire logic density_disable_pin_i, // hardware-mode density disable pin
  input wire logic eq_bypass_pin_i,       // hardware-mode equalizer bypass pin
  input wire logic [7:0] reg_addr_i,      // register address from serial port
  input wire logic reg_wr_i,              // register write strobe
  input wire logic [4:0] reg_wdata_i,     // register write data
  output logic [4:0] reg_rdata_o,         // register read data
  output logic signal_loss_out_o,         // loss-of-signal pin
  output logic codec_bypass_o,            // 1 = encoder and decoder bypassed
  output logic equalizer_bypass_o         // 1 = receive equalizer off
);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [3:0] pin1_r;
  logic [3:0] pin2_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      pin1_r <= 4'h0;
      pin2_r <= 4'h0;
    end else begin
      sync1_r <= {amp_below_i, lock_loss_i, drive_monitor_i};
      sync2_r <= sync1_r;
      pin1_r <= {codec_bypass_pin_i, amp_disable_pin_i, density_disable_pin_i, eq_bypass_pin_i};
      pin2_r <= pin1_r;
    end
  end

  // ****************************************************************
  // configuration register and effective controls
  // ****************************************************************
  line_loss_pkg::path_cfg_t cfg_r;
  line_loss_pkg::path_cfg_t ctrl;

  // written only through the register port
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_r <= line_loss_pkg::CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == line_loss_pkg::RECEIVE_PATH_CONFIG_ADDR) begin
      cfg_r.codec_bypass <= reg_wdata_i[line_loss_pkg::CFG_CODEC_BYPASS_BIT];
      cfg_r.amplitude_loss_disable <= reg_wdata_i[line_loss_pkg::CFG_AMP_DISABLE_BIT];
      cfg_r.pulse_density_loss_disable <= reg_wdata_i[line_loss_pkg::CFG_DENSITY_DISABLE_BIT];
      cfg_r.equalizer_bypass <= reg_wdata_i[line_loss_pkg::CFG_EQ_BYPASS_BIT];
    end
  end

  // pins replace the register when no host is attached
  assign ctrl = host_mode_i ? cfg_r : line_loss_pkg::path_cfg_t'(pin2_r);

  // ****************************************************************
  // amplitude and density detectors
  // ****************************************************************
  logic amp_loss_r;
  logic amp_loss;
  logic density_raw;
  logic density_loss;

  // comparator already applies threshold and hysteresis
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || ctrl.amplitude_loss_disable) begin
      amp_loss_r <= 1'b0;
    end else begin
      amp_loss_r <= sync2_r[2];
    end
  end

  // density criteria only apply outside E3
  pulse_density_detector u_density (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .bit_en_i(bit_en_i),
    .rx_bit_i(rx_bit_i),
    .disable_i(ctrl.pulse_density_loss_disable),
    .loss_o(density_raw)
  );

  // detectors drop a cycle after their disable; masking here keeps the status
  // bits, the OR and the both-off override consistent in that cycle
  assign amp_loss = amp_loss_r & ~ctrl.amplitude_loss_disable;
  assign density_loss = density_raw & ~ctrl.pulse_density_loss_disable;

  // ****************************************************************
  // E3 declare/clear filter
  // ****************************************************************
  logic e3_loss_r;
  logic [7:0] e3_cnt_r;

  // amplitude must disagree for E3_FILTER bit periods before the state flips;
  // a short glitch restarts the count, which trades speed for chatter immunity
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      e3_loss_r <= 1'b0;
      e3_cnt_r <= 8'h00;
    end else if (amp_loss_r == e3_loss_r) begin
      e3_cnt_r <= 8'h00;
    end else if (bit_en_i) begin
      if (e3_cnt_r == 8'(E3_FILTER - 1)) begin
        e3_loss_r <= amp_loss_r;
        e3_cnt_r <= 8'h00;
      end else begin
        e3_cnt_r <= e3_cnt_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // overall loss, outputs and status read
  // ****************************************************************
  logic overall_loss;
  line_loss_pkg::loss_status_t status;

  // both detectors off forces the overall loss low
  always_comb begin
    if (ctrl.amplitude_loss_disable && ctrl.pulse_density_loss_disable) begin
      overall_loss = 1'b0;
    end else if (mode_e3_i) begin
      overall_loss = e3_loss_r;
    end else begin
      overall_loss = amp_loss | density_loss;
    end
  end

  assign status = '{lock_loss_flag: sync2_r[1], signal_loss: overall_loss, amplitude_loss: amp_loss,
                    pulse_density_loss: density_loss, drive_monitor_flag: sync2_r[0]};

  // pin and status bit come from the same state, one cycle apart at most
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      signal_loss_out_o <= 1'b0;
      codec_bypass_o <= 1'b0;
      equalizer_bypass_o <= 1'b0;
    end else begin
      signal_loss_out_o <= overall_loss;
      codec_bypass_o <= ctrl.codec_bypass;
      equalizer_bypass_o <= ctrl.equalizer_bypass;
    end
  end

  // read data follows the address one cycle later; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 5'h00;
    end else if (reg_addr_i == line_loss_pkg::LINE_LOSS_STATUS_ADDR) begin
      reg_rdata_o <= status;
    end else if (reg_addr_i == line_loss_pkg::RECEIVE_PATH_CONFIG_ADDR) begin
      reg_rdata_o <= {1'b0, cfg_r};
    end else begin
      reg_rdata_o <= 5'h00;
    end
  end

endmodule // line_loss_monitor

// ===== line_source_model.sv
// partner model: recovered bit strobe and received data pattern
`timescale 1ns/10ps
module line_source_model (
  input wire logic clk_i,       // system clock
  input wire logic [1:0] pat_i, // 0 zeros, 1 ones, 2 random
  output logic bit_en_o,        // one pulse per bit
  output logic rx_bit_o         // received bit
);
  logic tog_r = 1'b0;
  logic val_r = 1'b1;
  // recovered bit every second cycle, new value each bit
  always @(posedge clk_i) begin
    tog_r <= ~tog_r;
    val_r <= (pat_i == 2'h2) ? 1'($urandom) : pat_i[0];
  end
  assign bit_en_o = tog_r;
  // off-strobe cycles show the inverse so a stale bit is never mistaken for data
  assign rx_bit_o = tog_r ? val_r : ~val_r;
endmodule // line_source_model

// ===== line_loss_checker_monitor.sv
// checker: port-level assertions for the loss monitor
`timescale 1ns/10ps
module line_loss_checker #(
  parameter int E3_FILTER = 32
) (
  input wire logic clk_i,              // clock
  input wire logic rst_b_i,            // reset, active low
  input wire logic host_mode_i,        // host mode
  input wire logic mode_e3_i,          // e3 rate
  input wire logic lock_loss_i,        // lock loss in
  input wire logic drive_monitor_i,    // drive monitor in
  input wire logic codec_bypass_pin_i, // bypass pin
  input wire logic [7:0] reg_addr_i,   // address
  input wire logic reg_wr_i,           // write strobe
  input wire logic [4:0] reg_wdata_i,  // write data
  input wire logic [4:0] reg_rdata_o,  // read data
  input wire logic signal_loss_out_o,  // loss pin
  input wire logic codec_bypass_o      // codec bypass
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ****************************************************************
  // assertions
  // ****************************************************************
  codec_pin_a: assert property ((!host_mode_i && $stable(codec_bypass_pin_i)) [*4]
    |=> codec_bypass_o == $past(codec_bypass_pin_i)) else $error("codec bypass does not follow pin");
  codec_host_a: assert property ((host_mode_i && reg_wr_i && reg_addr_i == 8'h02) ##1
    (host_mode_i && !reg_wr_i) ##1 host_mode_i |-> codec_bypass_o == $past(reg_wdata_i[3], 2))
    else $error("codec bypass does not follow config write");
  pin_status_a: assert property ($past(reg_addr_i) == 8'h00 |-> signal_loss_out_o == reg_rdata_o[3])
    else $error("loss pin differs from status");
  or_ds3_a: assert property ((!mode_e3_i) [*3] ##0 $past(reg_addr_i) == 8'h00
    |-> reg_rdata_o[3] == (reg_rdata_o[2] | reg_rdata_o[1])) else $error("loss is not or of detectors");
  unmapped_zero_a: assert property ($past(reg_addr_i) != 8'h00 && $past(reg_addr_i) != 8'h02
    |-> reg_rdata_o == 5'h00) else $error("unmapped read not zero");
  cfg_top_a: assert property ($past(reg_addr_i) == 8'h02 |-> !reg_rdata_o[4])
    else $error("reserved config bit reads one");
  both_off_a: assert property ((host_mode_i && $past(reg_addr_i) == 8'h02 && reg_rdata_o[2:1] == 2'h3) [*4]
    |-> !signal_loss_out_o) else $error("loss declared with both detectors off");
  lock_mon_a: assert property ((lock_loss_i && drive_monitor_i) [*4] ##1 $past(reg_addr_i) == 8'h00
    |-> reg_rdata_o[4] && reg_rdata_o[0]) else $error("lock or monitor flag missing");
  // main scenarios
  loss_c: cover property ($rose(signal_loss_out_o));
  e3_loss_c: cover property (mode_e3_i && $rose(signal_loss_out_o));
  bypass_c: cover property ($rose(codec_bypass_o));
endmodule // line_loss_checker
bind line_loss_monitor line_loss_checker #(.E3_FILTER(E3_FILTER)) u_chk (.clk_i, .rst_b_i, .host_mode_i,
  .mode_e3_i, .lock_loss_i, .drive_monitor_i, .codec_bypass_pin_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rdata_o, .signal_loss_out_o, .codec_bypass_o);

// ===== line_loss_monitor_tb_top.sv
// testbench: self-checking bench for the loss monitor
`timescale 1ns/10ps
module line_loss_monitor_tb_top;
  logic clk_i = 1'b0, rst_b_i = 1'b0, host_mode_i = 1'b1, mode_e3_i = 1'b0, amp_below_i = 1'b0;
  logic lock_loss_i = 1'b0, drive_monitor_i = 1'b0, cb_pin = 1'b0, ad_pin = 1'b0, dd_pin = 1'b0, eq_pin = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [4:0] reg_wdata_i = 5'h00, reg_rdata_o, w;
  logic signal_loss_out_o, codec_bypass_o, equalizer_bypass_o, bit_en, rx_bit;
  logic [1:0] pat = 2'h2;
  logic [5:0] v;
  int failures = 0, n_checks = 0, cyc = 0, n;
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  line_loss_monitor #(.E3_FILTER(32)) DUT (.clk_i, .rst_b_i, .host_mode_i, .mode_e3_i, .bit_en_i(bit_en),
    .rx_bit_i(rx_bit), .amp_below_i, .lock_loss_i, .drive_monitor_i, .codec_bypass_pin_i(cb_pin),
    .amp_disable_pin_i(ad_pin), .density_disable_pin_i(dd_pin), .eq_bypass_pin_i(eq_pin), .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .signal_loss_out_o, .codec_bypass_o, .equalizer_bypass_o);
  line_source_model u_src (.clk_i, .pat_i(pat), .bit_en_o(bit_en), .rx_bit_o(rx_bit));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [5:0] cfg_rd(input logic [4:0] d);
    return {2'h0, d[3:0]};
  endfunction
  // fewest bits to clear: a partly filled window with enough ones counts as the first good one
  function automatic int clear_min();
    return (line_loss_pkg::GOOD_WINDOWS - 1) * line_loss_pkg::WINDOW_UI + line_loss_pkg::WINDOW_MIN_ONES;
  endfunction
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [4:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wr_i <= 1'b1;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // holds the address long enough for the readback to settle
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    v = {signal_loss_out_o, reg_rdata_o};
    // hand back on a rising edge so the next stimulus lands there
    @(posedge clk_i);
  endtask
  // applies line stimulus, counts bits until pin/status bit p reaches val
  task automatic wt(input int p, input logic val, input logic [1:0] np, input logic amp);
    @(posedge clk_i);
    reg_addr_i <= 8'h00;
    pat <= np;
    amp_below_i <= amp;
    n = 0;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk_i);
      if (reg_rdata_o[p % 5] === val && p < 5 || p == 5 && signal_loss_out_o === val) break;
      if (bit_en === 1'b1) n++;
    end
  endtask
  // cycle ceiling so a hang still reaches the verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(32'hE7E4));
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h02);
    chk("cfg reset", 6'h00, v);
    rd(8'h05);
    chk("unmapped", 6'h00, {1'b0, v[4:0]});
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 5'h1F : (i == 1) ? 5'h08 : 5'($urandom);
      wr(8'h02, w);
      rd(8'h02);
      chk("cfg", cfg_rd(w), {1'b0, v[4:0]});
      chk("bypass", {4'h0, w[3], w[0]}, {4'h0, codec_bypass_o, equalizer_bypass_o});
    end
    wr(8'h00, 5'h1F);
    rd(8'h02);
    chk("status write", cfg_rd(w), {1'b0, v[4:0]});
    $display("test registers done");
    host_mode_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {cb_pin, eq_pin, lock_loss_i, drive_monitor_i, ad_pin, dd_pin} <= {3{i[1:0]}};
      rd(8'h00);
      chk("hw bypass", {4'h0, i[1:0]}, {4'h0, codec_bypass_o, equalizer_bypass_o});
      chk("lock monitor", {1'b0, i[1], 3'h0, i[0]}, v);
    end
    {cb_pin, eq_pin, lock_loss_i, drive_monitor_i, ad_pin, dd_pin} <= 6'h00;
    host_mode_i <= 1'b1;
    wr(8'h02, 5'h00);
    $display("test hardware mode done");
    wt(1, 1'b1, 2'h0, 1'b0);
    chk_rng("zero run", 128, 192, n);
    rd(8'h00);
    chk("density loss", 6'h2A, v);
    wt(1, 1'b0, 2'h1, 1'b0);
    chk_rng("good windows", clear_min(), 160, n);
    rd(8'h00);
    chk("density clear", 6'h00, v);
    wt(2, 1'b1, 2'h1, 1'b1);
    rd(8'h00);
    chk("amplitude loss", 6'h2C, v);
    wr(8'h02, 5'h04);
    rd(8'h00);
    chk("amp disabled", 6'h00, v);
    wt(1, 1'b1, 2'h0, 1'b1);
    rd(8'h00);
    chk("density only", 6'h2A, v);
    wr(8'h02, 5'h06);
    rd(8'h02);
    rd(8'h00);
    chk("both disabled", 6'h00, v);
    $display("test ds3 loss done");
    mode_e3_i <= 1'b1;
    wr(8'h02, 5'h00);
    wt(5, 1'b1, 2'h0, 1'b0);
    chk("e3 density ignored", 6'h00, {5'h00, signal_loss_out_o});
    wt(5, 1'b1, 2'h0, 1'b1);
    chk_rng("e3 declare", line_loss_pkg::E3_MIN_UI, line_loss_pkg::E3_MAX_UI, n);
    wt(5, 1'b0, 2'h1, 1'b0);
    chk_rng("e3 clear", line_loss_pkg::E3_MIN_UI, line_loss_pkg::E3_MAX_UI, n);
    $display("test e3 loss done");
    wrap_up();
  end
endmodule // line_loss_monitor_tb_top
